// *** core/i2cm_baud.sv ***
// reloadable baud generator: counts down once per load, stops and pulses when it reaches zero
`timescale 1ns/1ps
`default_nettype none
module i2cm_baud
    import i2cm_pkg::*;
(
    input wire logic mclk,   // system clock
    input wire logic reset,  // synchronous reset
    i2cm_baud_if.gen bif     // engine side
);
    logic [7:0] cnt;
    logic run;
    logic [7:0] next_cnt;
    logic next_run;
    logic next_tick;

    // count down from the reload value, stop and pulse at zero
    always_comb begin
        next_cnt = cnt;
        next_run = run;
        next_tick = 1'b0;
        if (bif.load) begin
            next_cnt = bif.reload;
            next_run = 1'b1;
        end else if (run) begin
            if (cnt == 8'h00) begin
                next_run = 1'b0;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt - 8'h01;
            end
        end
    end

    // register the counter
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt <= 8'h00;
            run <= 1'b0;
            bif.tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            run <= next_run;
            bif.tick <= next_tick;
        end
    end

    baud_reload_a: assert property (@(posedge mclk) disable iff (reset)
        bif.load |=> run && cnt == $past(bif.reload))
        else $error("baud generator did not take reload value");
endmodule : i2cm_baud
`default_nettype wire

// *** core/i2cm_engine.sv ***
// i2c master byte engine: transmit, receive, acknowledge and stop sequences
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module i2cm_engine
    import i2cm_pkg::*;
(
    input wire logic mclk,                // system clock, 10 MHz
    input wire logic reset,               // synchronous reset, active high
    input wire logic [ADDR_W-1:0] addr,   // register address
    input wire logic [7:0] wdata,         // write data
    input wire logic wr,                  // write strobe
    input wire logic rd,                  // read strobe
    output logic [7:0] rdata,             // read data, cycle after rd
    input wire logic scl_in,              // scl pin level
    output logic scl_out,                 // scl drive value, always low
    output logic scl_oe,                  // high while pulling scl low
    input wire logic sda_in,              // sda pin level
    output logic sda_out,                 // sda drive value, always low
    output logic sda_oe                   // high while pulling sda low
);
    i2cm_baud_if bif ();
    i2cm_baud u_baud (
        .mclk(mclk),
        .reset(reset),
        .bif(bif)
    );

    i2cm_state_e state, next_state;
    i2cm_phase_e phase, next_phase;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic [7:0] data_buf, next_data_buf;
    logic [7:0] baud_reg, next_baud_reg;
    logic receive_enable_bit, next_receive_enable_bit;
    logic ack_sequence_enable, next_ack_sequence_enable;
    logic stop_enable_bit, next_pen;
    logic ack_data_bit, next_ack_data_bit;
    logic ackst, next_ackst;
    logic bf, next_bf;
    logic write_collision_flag, next_write_collision_flag;
    logic ov, next_ov;
    logic intf, next_intf;
    logic stopd, next_stopd;
    logic next_scl_oe, next_sda_oe;
    logic [7:0] next_rdata;
    logic load_c;
    logic scl_m, scl_s, sda_m, sda_s;
    logic wr_data, wr_ctrl, wr_stat, idle;

    // two-stage synchronisers for the bus pins
    always_ff @(posedge mclk) begin
        if (reset) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            sda_m <= sda_in;
            sda_s <= sda_m;
        end
    end

    assign wr_data = wr && addr == REG_DATA;
    assign wr_ctrl = wr && addr == REG_CTRL;
    assign wr_stat = wr && addr == REG_STAT;
    assign idle = state == ST_IDLE;
    assign bif.load = load_c;
    assign bif.reload = baud_reg;

    // next state of the engine, flags and register file
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_data_buf = data_buf;
        next_baud_reg = baud_reg;
        next_receive_enable_bit = receive_enable_bit;
        next_ack_sequence_enable = ack_sequence_enable;
        next_pen = stop_enable_bit;
        next_ack_data_bit = ack_data_bit;
        next_ackst = ackst;
        next_bf = bf;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        load_c = 1'b0;
        // status flags: software clears with a one, hardware sets win below
        next_write_collision_flag = write_collision_flag && !(wr_stat && wdata[ST_WRITE_COLLISION_FLAG]);
        next_ov = ov && !(wr_stat && wdata[ST_OV]);
        next_intf = intf && !(wr_stat && wdata[ST_INT]);
        next_stopd = stopd && !(wr_stat && wdata[ST_STOP]);
        if (rd && addr == REG_DATA) begin
            next_bf = 1'b0;
        end
        if (wr && addr == REG_BAUD) begin
            next_baud_reg = wdata;
        end
        // software commands
        if (wr_data) begin
            if (idle) begin
                next_data_buf = wdata;
                next_shift = wdata;
                next_bf = 1'b1;
                next_state = ST_TX;
                next_phase = PH_FALL;
                next_bit_cnt = 4'h0;
            end else begin
                next_write_collision_flag = 1'b1;
            end
        end
        if (wr_ctrl) begin
            next_ack_data_bit = wdata[CTL_ACK_DATA_BIT];
            if (idle) begin
                next_phase = PH_FALL;
                next_bit_cnt = 4'h0;
                if (wdata[CTL_PEN]) begin
                    next_pen = 1'b1;
                    next_state = ST_STOPSEQ;
                end else if (wdata[CTL_ACK_SEQUENCE_ENABLE]) begin
                    next_ack_sequence_enable = 1'b1;
                    next_state = ST_ACK;
                end else if (wdata[CTL_RECEIVE_ENABLE_BIT]) begin
                    next_receive_enable_bit = 1'b1;
                    next_state = ST_RX;
                end
            end
        end
        // bit sequencer shared by all operations
        case (phase)
            PH_FALL: begin
                if (!idle) begin
                    next_scl_oe = 1'b1;
                    if (scl_oe && (state != ST_STOPSEQ || (sda_oe && !sda_s))) begin
                        load_c = 1'b1;
                        next_phase = PH_LOW;
                        case (state)
                            ST_TX: begin
                                next_sda_oe = (bit_cnt == LAST_TX_BIT) ? 1'b0 : !shift[7];
                                next_shift = {shift[6:0], 1'b0};
                            end
                            ST_RX: next_sda_oe = 1'b0;
                            ST_ACK: next_sda_oe = !ack_data_bit;
                            default: next_sda_oe = sda_oe;
                        endcase
                    end else if (state == ST_STOPSEQ) begin
                        next_sda_oe = 1'b1;
                    end
                end
            end
            PH_LOW: begin
                if (bif.tick) begin
                    next_scl_oe = 1'b0;
                    next_phase = PH_WAIT;
                end
            end
            PH_WAIT: begin
                if (scl_s) begin
                    load_c = 1'b1;
                    next_phase = PH_HIGH;
                    if (state == ST_TX && bit_cnt == LAST_TX_BIT) begin
                        next_ackst = sda_s;
                    end
                    if (state == ST_RX) begin
                        next_shift = {shift[6:0], sda_s};
                    end
                end
            end
            PH_HIGH: begin
                if (bif.tick) begin
                    next_scl_oe = 1'b1;
                    next_bit_cnt = bit_cnt + 4'h1;
                    next_phase = PH_FALL;
                    case (state)
                        ST_TX: begin
                            if (bit_cnt == LAST_RX_BIT) begin
                                next_bf = 1'b0;
                            end
                            if (bit_cnt == LAST_TX_BIT) begin
                                next_intf = 1'b1;
                                next_state = ST_IDLE;
                            end
                        end
                        ST_RX: begin
                            if (bit_cnt == LAST_RX_BIT) begin
                                next_receive_enable_bit = 1'b0;
                                next_data_buf = shift;
                                next_bf = 1'b1;
                                next_ov = next_ov || bf; // set beats a clear
                                next_intf = 1'b1;
                                next_state = ST_IDLE;
                            end
                        end
                        ST_ACK: begin
                            next_ack_sequence_enable = 1'b0;
                            next_intf = 1'b1;
                            next_state = ST_IDLE;
                        end
                        default: begin
                            next_scl_oe = 1'b0;
                            next_sda_oe = 1'b0;
                            next_phase = PH_SDAH;
                        end
                    endcase
                end
            end
            PH_SDAH: begin
                if (sda_s && scl_s) begin
                    next_stopd = 1'b1;
                    load_c = 1'b1;
                    next_phase = PH_LAST;
                end
            end
            PH_LAST: begin
                if (bif.tick) begin
                    next_pen = 1'b0;
                    next_intf = 1'b1;
                    next_state = ST_IDLE;
                    next_phase = PH_FALL;
                end
            end
            default: next_phase = PH_FALL;
        endcase
        // read data mux
        case (addr)
            REG_DATA: next_rdata = data_buf;
            REG_CTRL: next_rdata = {2'h0, ackst, 1'b0, ack_data_bit, stop_enable_bit, ack_sequence_enable, receive_enable_bit};
            REG_STAT: next_rdata = {2'h0, !idle, stopd, intf, ov, write_collision_flag, bf};
            default: next_rdata = baud_reg;
        endcase
        if (!rd) begin
            next_rdata = 8'h00;
        end
    end

    // register all state
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= ST_IDLE;
            phase <= PH_FALL;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            data_buf <= 8'h00;
            baud_reg <= BAUD_RESET;
            receive_enable_bit <= 1'b0;
            ack_sequence_enable <= 1'b0;
            stop_enable_bit <= 1'b0;
            ack_data_bit <= 1'b0;
            ackst <= 1'b0;
            bf <= 1'b0;
            write_collision_flag <= 1'b0;
            ov <= 1'b0;
            intf <= 1'b0;
            stopd <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            rdata <= 8'h00;
        end else begin
            state <= next_state;
            phase <= next_phase;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            data_buf <= next_data_buf;
            baud_reg <= next_baud_reg;
            receive_enable_bit <= next_receive_enable_bit;
            ack_sequence_enable <= next_ack_sequence_enable;
            stop_enable_bit <= next_pen;
            ack_data_bit <= next_ack_data_bit;
            ackst <= next_ackst;
            bf <= next_bf;
            write_collision_flag <= next_write_collision_flag;
            ov <= next_ov;
            intf <= next_intf;
            stopd <= next_stopd;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            rdata <= next_rdata;
        end
    end

    // checks on the sequencer
    tx_start_a: assert property (@(posedge mclk) disable iff (reset)
        wr_data && idle |=> bf && state == ST_TX && data_buf == $past(wdata))
        else $error("buffer write while idle did not start transmit");
    scl_low_hold_a: assert property (@(posedge mclk) disable iff (reset)
        phase == PH_LOW && !bif.tick |=> scl_oe)
        else $error("scl released before baud period ended");
    ack_release_a: assert property (@(posedge mclk) disable iff (reset)
        state == ST_TX && bit_cnt == LAST_TX_BIT && phase == PH_LOW |-> !sda_oe && !bf)
        else $error("sda not released for acknowledge");
    ack_capture_a: assert property (@(posedge mclk) disable iff (reset)
        state == ST_TX && bit_cnt == LAST_TX_BIT && phase == PH_WAIT && scl_s
        |=> ackst == $past(sda_s))
        else $error("acknowledge level not captured");
    tx_done_a: assert property (@(posedge mclk) disable iff (reset)
        state == ST_TX && bit_cnt == LAST_TX_BIT && phase == PH_HIGH && bif.tick
        |=> idle && intf && scl_oe && !sda_oe)
        else $error("transmit end did not park bus and interrupt");
    write_coll_a: assert property (@(posedge mclk) disable iff (reset)
        wr_data && !idle |=> write_collision_flag && data_buf == $past(data_buf))
        else $error("busy buffer write not flagged as collision");
    receive_enable_bit_ignore_a: assert property (@(posedge mclk) disable iff (reset)
        wr_ctrl && wdata[CTL_RECEIVE_ENABLE_BIT] && !idle && state != ST_RX |=> state != ST_RX)
        else $error("receive started while busy");
    rx_done_a: assert property (@(posedge mclk) disable iff (reset)
        state == ST_RX && bit_cnt == LAST_RX_BIT && phase == PH_HIGH && bif.tick
        |=> idle && bf && !receive_enable_bit && intf && scl_oe && data_buf == $past(shift))
        else $error("receive end sequence wrong");
    overflow_a: assert property (@(posedge mclk) disable iff (reset)
        state == ST_RX && bit_cnt == LAST_RX_BIT && phase == PH_HIGH && bif.tick && bf
        |=> ov)
        else $error("overflow not flagged");
    ack_drive_a: assert property (@(posedge mclk) disable iff (reset)
        state == ST_ACK && phase == PH_LOW |-> sda_oe == !ack_data_bit && scl_oe)
        else $error("ack data not driven");
    stop_end_a: assert property (@(posedge mclk) disable iff (reset)
        state == ST_STOPSEQ && phase == PH_LAST && bif.tick |=> !stop_enable_bit && intf && idle && stopd)
        else $error("stop completion wrong");
    stretch_a: assert property (@(posedge mclk) disable iff (reset)
        !idle && phase == PH_WAIT && !scl_s |=> phase == PH_WAIT && !bif.tick)
        else $error("baud ran while scl held low");
    tx_byte_c: cover property (@(posedge mclk) disable iff (reset)
        state == ST_TX ##1 state == ST_IDLE);
    rx_byte_c: cover property (@(posedge mclk) disable iff (reset)
        state == ST_RX ##1 state == ST_IDLE && ov);
    stop_seq_c: cover property (@(posedge mclk) disable iff (reset)
        state == ST_STOPSEQ ##1 state == ST_IDLE);
endmodule : i2cm_engine
`default_nettype wire

// *** inc/i2cm_baud_if.sv ***
// interface between the byte engine and its baud generator
`timescale 1ns/1ps
`default_nettype none
interface i2cm_baud_if;
    logic load;
    logic [7:0] reload;
    logic tick;
    modport engine (output load, output reload, input tick);
    modport gen (input load, input reload, output tick);
endinterface : i2cm_baud_if
`default_nettype wire

// *** inc/i2cm_pkg.sv ***
// package of constants and types for the i2c master byte engine
package i2cm_pkg;
    localparam int ADDR_W = 2;
    localparam logic [1:0] REG_DATA = 2'h0;
    localparam logic [1:0] REG_CTRL = 2'h1;
    localparam logic [1:0] REG_STAT = 2'h2;
    localparam logic [1:0] REG_BAUD = 2'h3;
    // control register fields
    localparam int CTL_RECEIVE_ENABLE_BIT = 0;
    localparam int CTL_ACK_SEQUENCE_ENABLE = 1;
    localparam int CTL_PEN = 2;
    localparam int CTL_ACK_DATA_BIT = 3;
    localparam int CTL_ACKST = 5;
    // status register fields, flags other than bf and busy are write one to clear, bf clears on a data read
    localparam int ST_BF = 0;
    localparam int ST_WRITE_COLLISION_FLAG = 1;
    localparam int ST_OV = 2;
    localparam int ST_INT = 3;
    localparam int ST_STOP = 4;
    localparam int ST_BUSY = 5;
    localparam logic [7:0] BAUD_RESET = 8'h09;
    localparam logic [3:0] LAST_TX_BIT = 4'h8;
    localparam logic [3:0] LAST_RX_BIT = 4'h7;
    typedef enum logic [2:0] {ST_IDLE, ST_TX, ST_RX, ST_ACK, ST_STOPSEQ} i2cm_state_e;
    typedef enum logic [2:0] {PH_FALL, PH_LOW, PH_WAIT, PH_HIGH, PH_SDAH, PH_LAST} i2cm_phase_e;
endpackage : i2cm_pkg

// *** verif/i2c_master_byte_engine_bench.sv ***
// self-checking bench: byte engine against a slave model on pulled-up wires
`timescale 1ns/1ps
`default_nettype none
module i2c_master_byte_engine_bench
    import i2cm_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic scl_out, scl_oe, sda_out, sda_oe, scl_oe_s, sda_oe_s, ack_seen;
    logic send_mode = 1'b0;
    logic ack_low = 1'b1;
    logic [4:0] stretch = 5'h00;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] rx_byte, stops, errs, v;
    int fails = 0;
    int cmp_count = 0;
    time t0, t_plain;
    // open-drain wires with pull-ups
    wire scl = !(scl_oe || scl_oe_s);
    wire sda = !(sda_oe || sda_oe_s);
    always #50 mclk = ~mclk;
    i2cm_engine i_dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
    i2cm_slave_model i_slave (.mclk(mclk), .reset(reset), .scl(scl), .sda(sda),
        .send_mode(send_mode), .ack_low(ack_low), .stretch(stretch), .tx_byte(tx_byte),
        .scl_oe_s(scl_oe_s), .sda_oe_s(sda_oe_s), .rx_byte(rx_byte), .ack_seen(ack_seen),
        .stops(stops), .errs(errs));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic wait_int(input logic stop_seq);
        logic [7:0] s;
        int n;
        s = 8'h00;
        n = 0;
        while (s[ST_INT] !== 1'b1 && n < 300) begin
            rd_reg(REG_STAT, s);
            if (stop_seq && s[ST_INT] === 1'b1) chk(s & 8'h10, 8'h10, "interrupt before stop");
            n++;
        end
        if (s[ST_INT] !== 1'b1) chk(8'h00, 8'h01, "interrupt wait ran out");
    endtask : wait_int
    task automatic t_reset();
        rd_reg(REG_STAT, v);
        chk(v, 8'h00, "status after reset");
        rd_reg(REG_CTRL, v);
        chk(v, 8'h00, "control after reset");
        rd_reg(REG_BAUD, v);
        chk(v, BAUD_RESET, "baud reload after reset");
        chk({6'h00, scl_oe, sda_oe}, 8'h00, "pins released after reset");
        chk({6'h00, scl_out, sda_out}, 8'h00, "pin drive values low");
        wr_reg(REG_BAUD, 8'h02);
        rd_reg(REG_BAUD, v);
        chk(v, 8'h02, "baud reload readback");
        $display("test reset done");
    endtask : t_reset
    task automatic t_tx();
        wr_reg(REG_DATA, 8'hA5);
        rd_reg(REG_STAT, v);
        chk(v & 8'h21, 8'h21, "buffer full and busy after load");
        wr_reg(REG_DATA, 8'h00);
        wait_int(1'b0);
        chk(rx_byte, 8'hA5, "address bits then direction bit");
        rd_reg(REG_STAT, v);
        chk(v & 8'h0B, 8'h0A, "collision and interrupt, buffer empty");
        rd_reg(REG_CTRL, v);
        chk(v & 8'h20, 8'h00, "slave acknowledge captured");
        chk({6'h00, scl_oe, sda_oe}, 8'h02, "scl held low, sda released");
        wr_reg(REG_STAT, 8'h1E);
        t0 = $time;
        wr_reg(REG_DATA, 8'h3C);
        wait_int(1'b0);
        t_plain = $time - t0;
        chk(rx_byte, 8'h3C, "data byte msb first");
        wr_reg(REG_STAT, 8'h1E);
        // stretched clock and a refused byte
        ack_low <= 1'b0;
        stretch <= 5'h0F;
        t0 = $time;
        wr_reg(REG_DATA, 8'h96);
        wait_int(1'b0);
        chk(rx_byte, 8'h96, "byte intact under stretching");
        chk(($time - t0 >= t_plain + 4000) ? 8'h01 : 8'h00, 8'h01, "low phase extended");
        rd_reg(REG_CTRL, v);
        chk(v & 8'h20, 8'h20, "no acknowledge captured");
        ack_low <= 1'b1;
        stretch <= 5'h00;
        wr_reg(REG_STAT, 8'h1E);
        $display("test transmit done");
    endtask : t_tx
    task automatic rx_one(input logic [7:0] b);
        tx_byte <= b;
        wr_reg(REG_CTRL, 8'h01);
        wr_reg(REG_DATA, 8'h55);
        wait_int(1'b0);
        rd_reg(REG_CTRL, v);
        chk(v & 8'h01, 8'h00, "receive enable cleared");
    endtask : rx_one
    task automatic ack_seq(input logic dt);
        wr_reg(REG_CTRL, {4'h0, dt, 3'h2});
        wr_reg(REG_CTRL, {4'h0, dt, 3'h1});
        wait_int(1'b0);
        chk({7'h00, ack_seen}, {7'h00, dt}, "acknowledge level clocked out");
        rd_reg(REG_CTRL, v);
        chk(v & 8'h07, 8'h00, "ack enable cleared, receive ignored");
        chk({7'h00, scl_oe}, 8'h01, "scl left low after acknowledge");
        wr_reg(REG_STAT, 8'h1E);
    endtask : ack_seq
    task automatic t_rx();
        send_mode <= 1'b1;
        rx_one(8'hC3);
        rd_reg(REG_STAT, v);
        chk(v & 8'h2F, 8'h0B, "full, interrupt, collision, idle");
        rd_reg(REG_DATA, v);
        chk(v, 8'hC3, "received byte");
        rd_reg(REG_STAT, v);
        chk(v & 8'h01, 8'h00, "buffer full cleared by read");
        wr_reg(REG_STAT, 8'h1E);
        ack_seq(1'b0);
        rx_one(8'h5A);
        wr_reg(REG_STAT, 8'h1E);
        ack_seq(1'b0);
        rx_one(8'h0F);
        rd_reg(REG_STAT, v);
        chk(v & 8'h05, 8'h05, "overflow with buffer still full");
        rd_reg(REG_DATA, v);
        chk(v, 8'h0F, "newest byte in buffer");
        wr_reg(REG_STAT, 8'h1E);
        ack_seq(1'b1);
        $display("test receive done");
    endtask : t_rx
    task automatic t_stop();
        send_mode <= 1'b0;
        wr_reg(REG_CTRL, 8'h04);
        wr_reg(REG_DATA, 8'h77);
        wait_int(1'b1);
        rd_reg(REG_STAT, v);
        chk(v & 8'h3A, 8'h1A, "stop detected, interrupt, collision");
        rd_reg(REG_CTRL, v);
        chk(v & 8'h04, 8'h00, "stop enable cleared");
        rd_reg(REG_DATA, v);
        chk(v, 8'h0F, "buffer unchanged by refused write");
        chk({6'h00, scl_oe, sda_oe}, 8'h00, "bus released after stop");
        chk(stops, 8'h01, "one stop condition on the wire");
        chk(errs, 8'h00, "sda steady while scl high");
        $display("test stop done");
    endtask : t_stop
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        $display("MISMATCH at %0t: run did not finish", $time);
        finish_test();
    end
    // main sequence
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_stop();
        finish_test();
    end
endmodule : i2c_master_byte_engine_bench
`default_nettype wire

// *** verif/i2cm_slave_model.sv ***
// behavioural i2c slave that answers the byte engine across the two wires
`timescale 1ns/1ps
`default_nettype none
module i2cm_slave_model (
    input wire logic mclk,          // sampling clock
    input wire logic reset,         // synchronous reset
    input wire logic scl,           // scl wire level
    input wire logic sda,           // sda wire level
    input wire logic send_mode,     // slave sends bytes to the master
    input wire logic ack_low,       // acknowledge bytes written by the master
    input wire logic [4:0] stretch, // cycles to hold scl low after a fall
    input wire logic [7:0] tx_byte, // byte sent in send mode
    output logic scl_oe_s,          // high while stretching scl
    output logic sda_oe_s,          // high while pulling sda low
    output logic [7:0] rx_byte,     // last bits written by the master
    output logic ack_seen,          // master acknowledge level in send mode
    output logic [7:0] stops,       // stop conditions seen
    output logic [7:0] errs         // sda falls while scl high
);
    logic scl_q;
    logic sda_q;
    logic [3:0] bitc;
    logic [4:0] stcnt;
    // data bits msb first, or the acknowledge after eight written bits
    always_comb begin
        if (send_mode) begin
            sda_oe_s = (bitc < 4'h8) && !tx_byte[3'h7 - bitc[2:0]];
        end else begin
            sda_oe_s = (bitc == 4'h8) && ack_low;
        end
        scl_oe_s = (stcnt != 5'h00);
    end
    // follow wire edges: count falls, take bits at rises, watch sda while scl high
    always @(posedge mclk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (reset) begin
            bitc <= 4'hF; // bus idle: the first scl fall opens bit 0
            stcnt <= 5'h00;
            rx_byte <= 8'h00;
            ack_seen <= 1'b0;
            stops <= 8'h00;
            errs <= 8'h00;
        end else begin
            if (stcnt != 5'h00) stcnt <= stcnt - 5'h01;
            if (scl_q && !scl) begin
                stcnt <= stretch;
                bitc <= (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
            end
            if (!scl_q && scl) begin
                if (bitc < 4'h8) rx_byte <= {rx_byte[6:0], sda};
                else ack_seen <= sda;
            end
            if (scl && scl_q && sda && !sda_q) begin
                stops <= stops + 8'h01;
                bitc <= 4'hF; // idle again until the next scl fall
            end
            if (scl && scl_q && !sda && sda_q) errs <= errs + 8'h01;
        end
    end
endmodule : i2cm_slave_model
`default_nettype wire
